// ---- ddg_pkg.sv ----
// package for the loop damping and gain configuration bank
package ddg_pkg;

  // ---------------------------------------------------------------
  // register indices and reset values
  // ---------------------------------------------------------------
  localparam logic [6:0] AUX_DAMP_ADDR   = 7'h00;
  localparam logic [6:0] OUT_DAMP_ADDR   = 7'h01;
  localparam logic [7:0] AUX_DAMP_RESET  = 8'h13;
  localparam logic [7:0] OUT_DAMP_RESET  = 8'h13;
  localparam logic [7:0] WRITABLE_MASK   = 8'h77;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int         DAMP_LSB        = 0;
  localparam int         GAIN_LSB        = 4;
  localparam logic [2:0] DAMP_DEFAULT    = 3'h3;

  // damping factor in tenths
  localparam logic [7:0] DF_1P2          = 8'h0c;
  localparam logic [7:0] DF_2P5          = 8'h19;
  localparam logic [7:0] DF_5            = 8'h32;
  localparam logic [7:0] DF_10           = 8'h64;
  localparam logic [7:0] DF_20           = 8'hc8;

  // bandwidth class: 0 =<4 Hz, 1 = 8 Hz, 2 = 18 Hz, 3 = 35 Hz, 4 = 70 Hz
  localparam logic [2:0] BW_LE4          = 3'h0;
  localparam logic [2:0] BW_8            = 3'h1;
  localparam logic [2:0] BW_18           = 3'h2;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ddg_req_s;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } ddg_rsp_s;

  typedef struct packed {
    logic [2:0] aux_gain;
    logic [2:0] aux_damp;
    logic [2:0] out_gain;
    logic [2:0] out_damp;
    ddg_rsp_s   rsp;
  } ddg_state_s;

endpackage

// ---- ddg_damping_gain_regs.sv ----
// two loop damping and low-frequency gain configuration registers
// Operation
// - each register: damping select in [2:0], low-frequency analog gain in [6:4]
// - both registers read and write; bits 7 and 3 unused, read zero
// - damping code maps to 1.2/2.5/5/10/20 depending on selected bandwidth
// - damping select resets to 011, factor 5 at every bandwidth
// - auxiliary loop gain field sets detector two gain at 8 kHz or less
// - gain field ignored unless the detector two gain enable bit is set
// - transmit-output loop gain field likewise sets low-frequency analog gain
// - enable clear: detector unused; set: gain chosen by mode and reference
`timescale 1ns/1ps
module ddg_damping_gain_regs
  import ddg_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire ddg_pkg::ddg_req_s  req,
  output ddg_pkg::ddg_rsp_s       rsp,
  input  wire logic [2:0]         aux_bandwidth_class,
  input  wire logic [2:0]         out_bandwidth_class,
  input  wire logic               aux_pd_two_gain_select_enable,
  input  wire logic               out_pd_two_gain_select_enable,
  input  wire logic               aux_lowfreq_analog_mode,
  input  wire logic               out_lowfreq_analog_mode,
  output logic [7:0]              aux_damping_factor,
  output logic [7:0]              out_damping_factor,
  output logic                    aux_pd_two_lowfreq_gain_valid,
  output logic [2:0]              aux_pd_two_lowfreq_analog_gain,
  output logic                    out_pd_two_lowfreq_gain_valid,
  output logic [2:0]              out_pd_two_lowfreq_analog_gain
);
  import ddg_pkg::*;

  // ---------------------------------------------------------------
  // damping lookup
  // ---------------------------------------------------------------
  function automatic logic [7:0] damp_factor(input logic [2:0] code, input logic [2:0] bw);
    logic [7:0] f;
    f = DF_5;
    case (code)
      3'h1: f = (bw == BW_LE4) ? DF_5 : (bw == BW_8) ? DF_2P5 : DF_1P2;
      3'h2: f = (bw == BW_LE4 || bw == BW_8) ? DF_5 : DF_2P5;
      3'h3: f = DF_5;
      3'h4: f = (bw == BW_LE4) ? DF_5 : DF_10;
      3'h5: f = (bw == BW_LE4) ? DF_5 : (bw == BW_8 || bw == BW_18) ? DF_10 : DF_20;
      default: f = DF_5;
    endcase
    return f;
  endfunction

  function automatic logic [7:0] pack_reg(input logic [2:0] gain, input logic [2:0] damp);
    return {1'b0, gain, 1'b0, damp};
  endfunction

  ddg_state_s st_reg;
  ddg_state_s st_next;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next            = st_reg;
    st_next.rsp.rvalid = 1'b0;
    if (req.wr_en && req.addr == AUX_DAMP_ADDR)
    begin
      st_next.aux_damp = req.wdata[DAMP_LSB +: 3];
      st_next.aux_gain = req.wdata[GAIN_LSB +: 3];
    end
    if (req.wr_en && req.addr == OUT_DAMP_ADDR)
    begin
      st_next.out_damp = req.wdata[DAMP_LSB +: 3];
      st_next.out_gain = req.wdata[GAIN_LSB +: 3];
    end
    if (req.rd_en)
    begin
      st_next.rsp.rvalid = 1'b1;
      if (req.addr == AUX_DAMP_ADDR)
        st_next.rsp.rdata = pack_reg(st_reg.aux_gain, st_reg.aux_damp);
      else if (req.addr == OUT_DAMP_ADDR)
        st_next.rsp.rdata = pack_reg(st_reg.out_gain, st_reg.out_damp);
      else
        st_next.rsp.rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg.aux_gain   <= AUX_DAMP_RESET[GAIN_LSB +: 3];
      st_reg.aux_damp   <= AUX_DAMP_RESET[DAMP_LSB +: 3];
      st_reg.out_gain   <= OUT_DAMP_RESET[GAIN_LSB +: 3];
      st_reg.out_damp   <= OUT_DAMP_RESET[DAMP_LSB +: 3];
      st_reg.rsp.rvalid <= 1'b0;
      st_reg.rsp.rdata  <= 8'h00;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // outputs to the loops
  // ---------------------------------------------------------------
  assign rsp                = st_reg.rsp;
  assign aux_damping_factor = damp_factor(st_reg.aux_damp, aux_bandwidth_class);
  assign out_damping_factor = damp_factor(st_reg.out_damp, out_bandwidth_class);
  // gain reaches the detector whenever enabled; valid also needs low-frequency analog mode
  assign aux_pd_two_lowfreq_gain_valid  = aux_pd_two_gain_select_enable
                                        && aux_lowfreq_analog_mode;
  assign aux_pd_two_lowfreq_analog_gain = aux_pd_two_gain_select_enable
                                        ? st_reg.aux_gain : 3'h0;
  assign out_pd_two_lowfreq_gain_valid  = out_pd_two_gain_select_enable
                                        && out_lowfreq_analog_mode;
  assign out_pd_two_lowfreq_analog_gain = out_pd_two_gain_select_enable
                                        ? st_reg.out_gain : 3'h0;

  // ---------------------------------------------------------------
  // access sequences
  // ---------------------------------------------------------------
  sequence s_aux_write;
    req.wr_en && req.addr == AUX_DAMP_ADDR;
  endsequence

  sequence s_aux_read;
    req.rd_en && req.addr == AUX_DAMP_ADDR;
  endsequence

  sequence s_out_write;
    req.wr_en && req.addr == OUT_DAMP_ADDR;
  endsequence

  sequence s_out_read;
    req.rd_en && req.addr == OUT_DAMP_ADDR;
  endsequence

  // accesses outside the two implemented indices
  sequence s_foreign_write;
    req.wr_en && req.addr != AUX_DAMP_ADDR && req.addr != OUT_DAMP_ADDR;
  endsequence

  sequence s_foreign_read;
    req.rd_en && req.addr != AUX_DAMP_ADDR && req.addr != OUT_DAMP_ADDR;
  endsequence

  // ---------------------------------------------------------------
  // register access checks
  // ---------------------------------------------------------------
  // stored fields come back on the next read
  a_write_read_back: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_aux_write ##1 s_aux_read
    |=> rsp.rvalid && rsp.rdata == ($past(req.wdata, 2) & WRITABLE_MASK))
    else $error("aux register read back mismatch");
  a_out_read_back: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_out_write ##1 s_out_read
    |=> rsp.rvalid && rsp.rdata == ($past(req.wdata, 2) & WRITABLE_MASK))
    else $error("out register read back mismatch");
  a_unused_bits_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    rsp.rvalid |-> rsp.rdata[7] == 1'b0 && rsp.rdata[3] == 1'b0)
    else $error("unused bits not zero");
  // unused indices read zero and swallow writes
  a_foreign_read_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_foreign_read |=> rsp.rvalid && rsp.rdata == 8'h00)
    else $error("read of unused index not zero");
  a_foreign_write_ignored: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_foreign_write
    |=> $stable({st_reg.aux_gain, st_reg.aux_damp, st_reg.out_gain, st_reg.out_damp}))
    else $error("write to unused index changed a register");
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    !req.rd_en |=> $stable(rsp.rdata))
    else $error("read data changed without a read");
  a_read_one_cycle: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.rd_en |=> rsp.rvalid ##1 (rsp.rvalid == $past(req.rd_en)))
    else $error("read answer timing wrong");

  // ---------------------------------------------------------------
  // damping checks
  // ---------------------------------------------------------------
  a_default_factor_five: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.aux_damp == DAMP_DEFAULT |-> aux_damping_factor == DF_5)
    else $error("default code not factor five");
  a_out_default_five: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.out_damp == DAMP_DEFAULT |-> out_damping_factor == DF_5)
    else $error("out default code not factor five");
  // lowest bandwidth gives five for every code
  a_low_band_five: assert property (@(posedge core_clk) disable iff (!arst_n)
    aux_bandwidth_class == BW_LE4 |-> aux_damping_factor == DF_5)
    else $error("aux factor not five at lowest bandwidth");
  a_narrow_code_one: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.aux_damp == 3'h1 && aux_bandwidth_class == BW_18 |-> aux_damping_factor == DF_1P2)
    else $error("code one at 18 Hz not 1.2");
  a_factor_steep_code: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_reg.aux_damp == 3'h5 && aux_bandwidth_class == 3'h4 |-> aux_damping_factor == DF_20)
    else $error("code five at 70 Hz not 20");
  // reserved codes fall back to the default factor
  a_aux_reserved_default: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.aux_damp == 3'h0 || st_reg.aux_damp[2:1] == 2'b11) |-> aux_damping_factor == DF_5)
    else $error("aux reserved code not default factor");
  a_reserved_code_default: assert property (@(posedge core_clk) disable iff (!arst_n)
    (st_reg.out_damp == 3'h0 || st_reg.out_damp[2:1] == 2'b11) |-> out_damping_factor == DF_5)
    else $error("reserved code not default factor");

  // ---------------------------------------------------------------
  // detector two gain checks
  // ---------------------------------------------------------------
  a_gain_gated_off: assert property (@(posedge core_clk) disable iff (!arst_n)
    !aux_pd_two_gain_select_enable |-> !aux_pd_two_lowfreq_gain_valid
      && aux_pd_two_lowfreq_analog_gain == 3'h0)
    else $error("aux gain used while disabled");
  a_out_gain_gated: assert property (@(posedge core_clk) disable iff (!arst_n)
    !out_pd_two_gain_select_enable |-> !out_pd_two_lowfreq_gain_valid
      && out_pd_two_lowfreq_analog_gain == 3'h0)
    else $error("out gain used while disabled");
  a_valid_needs_mode: assert property (@(posedge core_clk) disable iff (!arst_n)
    !aux_lowfreq_analog_mode |-> !aux_pd_two_lowfreq_gain_valid)
    else $error("aux gain valid outside low-frequency analog mode");
  // field reaches the detector one cycle after the write
  a_aux_gain_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_aux_write ##1 aux_pd_two_gain_select_enable
    |-> aux_pd_two_lowfreq_analog_gain == $past(req.wdata[GAIN_LSB +: 3]))
    else $error("aux gain not from written field");
  a_out_gain_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_out_write ##1 out_pd_two_gain_select_enable
    |-> out_pd_two_lowfreq_analog_gain == $past(req.wdata[GAIN_LSB +: 3]))
    else $error("out gain not from written field");

endmodule

// ---- testbench.sv ----
// self-checking bench for the loop damping and gain configuration bank
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module testbench;
  import ddg_pkg::*;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  logic       core_clk = 1'b0;
  logic       arst_n   = 1'b0;
  ddg_req_s   req      = '0;
  ddg_rsp_s   rsp;
  logic [2:0] aux_bw   = 3'h0;
  logic [2:0] out_bw   = 3'h0;
  logic       aux_en   = 1'b0;
  logic       out_en   = 1'b0;
  logic       aux_mode = 1'b0;
  logic       out_mode = 1'b0;
  logic [7:0] aux_df, out_df;
  logic       aux_vld, out_vld;
  logic [2:0] aux_gain, out_gain;
  int         n_fail = 0;
  int         checks_done = 0;
  always #12.5 core_clk = ~core_clk;
  ddg_damping_gain_regs dut_u (.core_clk(core_clk), .arst_n(arst_n), .req(req), .rsp(rsp),
    .aux_bandwidth_class(aux_bw), .out_bandwidth_class(out_bw),
    .aux_pd_two_gain_select_enable(aux_en), .out_pd_two_gain_select_enable(out_en),
    .aux_lowfreq_analog_mode(aux_mode), .out_lowfreq_analog_mode(out_mode),
    .aux_damping_factor(aux_df), .out_damping_factor(out_df),
    .aux_pd_two_lowfreq_gain_valid(aux_vld), .aux_pd_two_lowfreq_analog_gain(aux_gain),
    .out_pd_two_lowfreq_gain_valid(out_vld), .out_pd_two_lowfreq_analog_gain(out_gain));
  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #2 req = '0;
    @(posedge core_clk);
    #2;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #2 req = '0;
    `CHK("rvalid", 1'b1, rsp.rvalid)
    `CHK("rdata", e, rsp.rdata)
    @(posedge core_clk);
    #2;
    `CHK("rvalid_drop", 1'b0, rsp.rvalid)
    `CHK("rdata_hold", e, rsp.rdata)
  endtask
  function automatic logic [7:0] exp_df(input logic [2:0] c, input logic [2:0] b);
    case (c)
      3'h1: exp_df = (b == 3'h0) ? DF_5 : (b == 3'h1) ? DF_2P5 : DF_1P2;
      3'h2: exp_df = (b < 3'h2) ? DF_5 : DF_2P5;
      3'h4: exp_df = (b == 3'h0) ? DF_5 : DF_10;
      3'h5: exp_df = (b == 3'h0) ? DF_5 : (b < 3'h3) ? DF_10 : DF_20;
      default: exp_df = DF_5;
    endcase
  endfunction
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_access();
    rd(7'h00, 8'h13);
    rd(7'h01, 8'h13);
    `CHK("aux_df", DF_5, aux_df)
    `CHK("out_df", DF_5, out_df)
    wr(7'h00, 8'hff);
    rd(7'h00, 8'h77);
    wr(7'h01, 8'h88);
    rd(7'h01, 8'h00);
    wr(7'h05, 8'h25);
    rd(7'h05, 8'h00);
    rd(7'h00, 8'h77);
  endtask
  task automatic t_damping_table();
    for (int c = 0; c < 8; c++)
    begin
      wr(7'h00, {5'h02, c[2:0]});
      wr(7'h01, {5'h02, c[2:0]});
      rd(7'h00, {5'h02, c[2:0]});
      for (int b = 0; b < 5; b++)
      begin
        aux_bw = b[2:0];
        out_bw = 3'(4 - b);
        #1;
        `CHK("aux_df", exp_df(c[2:0], b[2:0]), aux_df)
        `CHK("out_df", exp_df(c[2:0], 3'(4 - b)), out_df)
        @(posedge core_clk);
        #2;
      end
    end
  endtask
  task automatic t_gain_select();
    {aux_en, out_en} = 2'h3;
    wr(7'h00, 8'h53);
    wr(7'h01, 8'h63);
    for (int i = 0; i < 4; i++)
    begin
      {aux_en, aux_mode} = i[1:0];
      {out_en, out_mode} = 2'(3 - i);
      #1;
      `CHK("aux_vld", aux_en & aux_mode, aux_vld)
      `CHK("aux_gain", aux_en ? 3'h5 : 3'h0, aux_gain)
      `CHK("out_vld", out_en & out_mode, out_vld)
      `CHK("out_gain", out_en ? 3'h6 : 3'h0, out_gain)
      @(posedge core_clk);
      #2;
    end
  endtask
  task automatic t_back_to_back();
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: 7'h00, wdata: 8'h25};
    @(posedge core_clk);
    #2 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: 7'h00, wdata: 8'h00};
    @(posedge core_clk);
    #2 req = '{wr_en: 1'b1, rd_en: 1'b1, addr: 7'h01, wdata: 8'h4a};
    `CHK("rdata_b2b", 8'h25, rsp.rdata)
    @(posedge core_clk);
    #2 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: 7'h01, wdata: 8'h00};
    `CHK("rdata_old", 8'h63, rsp.rdata)
    @(posedge core_clk);
    #2 req = '0;
    `CHK("rdata_new", 8'h42, rsp.rdata)
    `CHK("rvalid_b2b", 1'b1, rsp.rvalid)
    @(posedge core_clk);
    #2;
  endtask
  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic final_report();
    if (n_fail == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    #2 arst_n = 1'b1;
    t_reset_and_access();
    t_damping_table();
    t_gain_select();
    t_back_to_back();
    final_report();
  end
endmodule
